// file: hdl/crcg_params.svh
// Purpose: named offsets, keys and counts of the cpu register file and config guard
// Assumes: register indices are word indices on apb, byte address is four times index
// Notes:   definitions only
`ifndef CRCG_PARAMS_SVH
`define CRCG_PARAMS_SVH

// apb register indices (byte address = index * 4)
`define CRCG_IDX_GUARD  6'h04
`define CRCG_IDX_SPL    6'h0D
`define CRCG_IDX_SPH    6'h0E
`define CRCG_IDX_STATUS_FLAGS   6'h0F
`define CRCG_IDX_TEMP   6'h10

// guard keys and layout
`define CRCG_KEY_IO     8'hD8
`define CRCG_KEY_SPM    8'h9D
`define CRCG_WIN_INSTR  3'h4
`define CRCG_BIT_IO     0
`define CRCG_BIT_SPM    1

// pointer pair low addresses
`define CRCG_PTR_X      5'h1A
`define CRCG_PTR_Y      5'h1C
`define CRCG_PTR_Z      5'h1E

// reset values
`define CRCG_STATUS_FLAGS_RST   8'h00
`define CRCG_BYTE_RST   8'h00
`define CRCG_SP_RST     16'h0FFF

`endif

// file: hdl/crcg_pkg.sv
// Purpose: types shared by the register file and config guard
// Assumes: one-hot guard states
// Notes:   constants live in crcg_params.svh
package crcg_pkg;
    typedef enum logic [2:0] {
        CRCG_CLOSED = 3'b001,
        CRCG_IO     = 3'b010,
        CRCG_SPM    = 3'b100
    } crcg_guard_e;

    typedef enum logic [1:0] {
        CRCG_DISP = 2'b00,
        CRCG_INC  = 2'b01,
        CRCG_DEC  = 2'b10
    } crcg_ptr_mode_e;
endpackage

// file: hdl/crcg_top.sv
// Purpose: working register file with pointer pairs, 8-bit temp byte, config change guard
// Assumes: cpu core drives the register ports and instruction events; apb reaches cpu registers
// Notes:   read data and pointer addresses are registered, valid one cycle after request
`timescale 1ns/100ps
`include "crcg_params.svh"

module crcg_top #(
    parameter logic [15:0] SP_RESET = `CRCG_SP_RST
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic [7:0]              paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [4:0]              rd_a_addr,
    input  wire logic [4:0]              rd_b_addr,
    output logic      [7:0]              rd_a_data,
    output logic      [7:0]              rd_b_data,
    output logic      [15:0]             rd_w_data,
    input  wire logic                    wr_en,
    input  wire logic                    wr_wide,
    input  wire logic [4:0]              wr_addr,
    input  wire logic [15:0]             wr_data,
    input  wire logic                    ptr_go,
    input  wire logic [1:0]              ptr_sel,
    input  wire crcg_pkg::crcg_ptr_mode_e ptr_mode,
    input  wire logic [5:0]              ptr_disp,
    output logic      [15:0]             ptr_addr,
    output logic      [15:0]             code_ptr,
    input  wire logic                    instr_done,
    input  wire logic                    io_data_wr,
    input  wire logic                    nvm_access,
    input  wire logic                    sleep_exec,
    input  wire logic                    prot_io_wr,
    input  wire logic                    nvm_cmd_wr,
    output logic                         prot_io_ok,
    output logic                         nvm_cmd_ok,
    input  wire logic                    irq_req,
    output logic                         irq_hold,
    output logic                         irq_take
);
    import crcg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    logic [5:0] idx;
    logic       acc;
    logic       apb_wr;
    logic       apb_rd;
    logic       mapped;
    logic [7:0] wbyte;

    assign idx    = paddr[7:2];
    assign acc    = psel & penable & pready;
    assign apb_wr = acc & pwrite;
    assign apb_rd = acc & ~pwrite;
    assign wbyte  = pwdata[7:0];
    assign mapped = (idx == `CRCG_IDX_GUARD) || (idx == `CRCG_IDX_SPL) || (idx == `CRCG_IDX_SPH)
                 || (idx == `CRCG_IDX_STATUS_FLAGS) || (idx == `CRCG_IDX_TEMP);

    ////////////////////////////////////////////////////////////////////////////
    // cpu registers behind apb: stack pointer, flags, temp byte
    logic [15:0] sp;
    logic [15:0] next_sp;
    logic [7:0]  status_flags;
    logic [7:0]  next_status_flags;
    logic [7:0]  temp;
    logic [7:0]  next_temp;
    logic        rdy;
    logic        next_rdy;
    logic [31:0] next_prdata;
    logic        next_err;
    logic [7:0]  guard_view;

    // effects land only on the completing edge, prdata is built at setup
    always_comb
    begin
        next_sp     = sp;
        next_status_flags   = status_flags;
        next_temp   = temp;
        next_rdy    = psel & ~penable & ~rdy;
        next_prdata = prdata;
        next_err    = pslverr;
        if (psel && !penable)
        begin
            next_err    = ~mapped;
            next_prdata = 32'h0000_0000;
            unique case (idx)
                `CRCG_IDX_GUARD: next_prdata[7:0] = guard_view;
                `CRCG_IDX_SPL:   next_prdata[7:0] = sp[7:0];
                `CRCG_IDX_SPH:   next_prdata[7:0] = temp;
                `CRCG_IDX_STATUS_FLAGS:  next_prdata[7:0] = status_flags;
                `CRCG_IDX_TEMP:  next_prdata[7:0] = temp;
                default:         next_prdata[7:0] = 8'h00;
            endcase
        end
        if (apb_rd && idx == `CRCG_IDX_SPL)
            next_temp = sp[15:8];
        if (apb_wr)
        begin
            unique case (idx)
                `CRCG_IDX_SPL:  next_temp = wbyte;
                `CRCG_IDX_SPH:  next_sp   = {wbyte, temp};
                `CRCG_IDX_STATUS_FLAGS: next_status_flags = wbyte;
                `CRCG_IDX_TEMP: next_temp = wbyte;
                default:        next_temp = next_temp;
            endcase
        end
    end

    // zero-wait slave: pready rises for the single access cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sp      <= SP_RESET;
            status_flags    <= `CRCG_STATUS_FLAGS_RST;
            temp    <= `CRCG_BYTE_RST;
            rdy     <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            sp      <= next_sp;
            status_flags    <= next_status_flags;
            temp    <= next_temp;
            rdy     <= next_rdy;
            prdata  <= next_prdata;
            pslverr <= next_err;
        end
    end
    assign pready = rdy;

    ////////////////////////////////////////////////////////////////////////////
    // working register file, private to the core ports (no apb path)
    logic [7:0]  rf      [32];
    logic [7:0]  next_rf [32];
    logic [4:0]  pbase;
    logic [4:0]  phigh;
    logic [15:0] pval;
    logic [15:0] pnew;
    logic [15:0] next_ptr;

    // third pair is fixed for code-side addressing
    always_comb
    begin
        unique case (ptr_sel)
            2'b00:   pbase = `CRCG_PTR_X;
            2'b01:   pbase = `CRCG_PTR_Y;
            default: pbase = `CRCG_PTR_Z;
        endcase
        phigh    = {pbase[4:1], 1'b1};
        pval     = {rf[phigh], rf[pbase]};
        pnew     = (ptr_mode == CRCG_INC) ? pval + 16'h0001 : pval - 16'h0001;
        unique case (ptr_mode)
            CRCG_INC: next_ptr = pval;
            CRCG_DEC: next_ptr = pnew;
            default:  next_ptr = pval + {10'h000, ptr_disp};
        endcase
    end

    // pointer writeback follows the operand write so it wins on the same pair
    always_comb
    begin
        next_rf = rf;
        if (wr_en)
        begin
            if (wr_wide)
            begin
                next_rf[{wr_addr[4:1], 1'b0}] = wr_data[7:0];
                next_rf[{wr_addr[4:1], 1'b1}] = wr_data[15:8];
            end
            else
                next_rf[wr_addr] = wr_data[7:0];
        end
        if (ptr_go && ptr_mode != CRCG_DISP)
        begin
            next_rf[pbase] = pnew[7:0];
            next_rf[phigh] = pnew[15:8];
        end
    end

    // every port answers on the next edge: one-cycle access
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rf        <= '{default: `CRCG_BYTE_RST};
            rd_a_data <= 8'h00;
            rd_b_data <= 8'h00;
            rd_w_data <= 16'h0000;
            ptr_addr  <= 16'h0000;
            code_ptr  <= 16'h0000;
        end
        else
        begin
            rf        <= next_rf;
            rd_a_data <= rf[rd_a_addr];
            rd_b_data <= rf[rd_b_addr];
            rd_w_data <= {rf[{rd_a_addr[4:1], 1'b1}], rf[{rd_a_addr[4:1], 1'b0}]};
            ptr_addr  <= ptr_go ? next_ptr : ptr_addr;
            code_ptr  <= {rf[`CRCG_PTR_Z + 5'h01], rf[`CRCG_PTR_Z]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // config change guard
    crcg_guard_e gst;
    crcg_guard_e next_gst;
    logic [2:0]  cnt;
    logic [2:0]  next_cnt;
    logic        key_wr;
    logic        io_close;

    assign key_wr   = apb_wr && idx == `CRCG_IDX_GUARD;
    // any other apb write is itself an io write
    assign io_close = io_data_wr | nvm_access | sleep_exec | (apb_wr & ~key_wr);
    assign guard_view = {6'h00, gst == CRCG_SPM, gst == CRCG_IO};

    // a key written in the closing cycle still opens a fresh window
    always_comb
    begin
        next_gst = gst;
        next_cnt = cnt;
        if (gst != CRCG_CLOSED && instr_done)
        begin
            next_cnt = cnt - 3'h1;
            if (cnt == 3'h1)
                next_gst = CRCG_CLOSED;
        end
        if (gst == CRCG_IO && io_close)
            next_gst = CRCG_CLOSED;
        if (gst == CRCG_SPM && (nvm_access || sleep_exec))
            next_gst = CRCG_CLOSED;
        if (key_wr)
        begin
            next_cnt = `CRCG_WIN_INSTR;
            if (wbyte == `CRCG_KEY_IO)
                next_gst = CRCG_IO;
            else if (wbyte == `CRCG_KEY_SPM)
                next_gst = CRCG_SPM;
            else
                next_gst = CRCG_CLOSED;
        end
    end

    // interrupts wait while a window is open; arbitration stays in the core
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gst        <= CRCG_CLOSED;
            cnt        <= 3'h0;
            prot_io_ok <= 1'b0;
            nvm_cmd_ok <= 1'b0;
            irq_hold   <= 1'b0;
            irq_take   <= 1'b0;
        end
        else
        begin
            gst        <= next_gst;
            cnt        <= next_cnt;
            prot_io_ok <= prot_io_wr & (gst == CRCG_IO);
            nvm_cmd_ok <= nvm_cmd_wr & (gst == CRCG_SPM);
            irq_hold   <= next_gst != CRCG_CLOSED;
            irq_take   <= irq_req & (next_gst == CRCG_CLOSED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_io_key_opens: assert property (key_wr && wbyte == `CRCG_KEY_IO |=> gst == CRCG_IO ##0 irq_hold)
        else $error("io key did not open window");
    a_spm_key_opens: assert property (key_wr && wbyte == `CRCG_KEY_SPM |=> gst == CRCG_SPM)
        else $error("spm key did not open window");
    a_bad_key_shut: assert property (key_wr && wbyte != `CRCG_KEY_IO && wbyte != `CRCG_KEY_SPM
        |=> gst == CRCG_CLOSED && !irq_hold)
        else $error("bad key left window open");
    a_window_four: assert property (key_wr ##1 (!key_wr && instr_done)[*4] |=> gst == CRCG_CLOSED)
        else $error("window outlived four instructions");
    a_io_close_wr: assert property (gst == CRCG_IO && io_data_wr && !key_wr |=> gst == CRCG_CLOSED)
        else $error("io window survived a write");
    a_spm_close_nv: assert property (gst == CRCG_SPM && (nvm_access || sleep_exec) && !key_wr
        |=> gst == CRCG_CLOSED)
        else $error("spm window survived nvm access");
    a_irq_gated: assert property (gst != CRCG_CLOSED |-> irq_hold && !irq_take)
        else $error("interrupt taken inside window");
    a_guard_view: assert property (psel && !penable && idx == `CRCG_IDX_GUARD
        |=> prdata[7:2] == 6'h00 && prdata[1:0] == {$past(gst) == CRCG_SPM, $past(gst) == CRCG_IO})
        else $error("guard read value wrong");
    a_sp_atomic: assert property (apb_wr && idx == `CRCG_IDX_SPH
        |=> sp == {$past(wbyte), $past(temp)})
        else $error("sp high write not atomic");
    a_temp_catch: assert property (apb_rd && idx == `CRCG_IDX_SPL |=> temp == $past(sp[15:8]))
        else $error("temp missed high byte");
    a_ptr_incr: assert property (ptr_go && ptr_mode == CRCG_INC && !wr_en
        |=> {rf[$past(phigh)], rf[$past(pbase)]} == $past(pval) + 16'h0001)
        else $error("pointer increment lost");

    c_io_unlock: cover property (key_wr && wbyte == `CRCG_KEY_IO ##[1:4] prot_io_ok);
    c_spm_cmd: cover property (key_wr && wbyte == `CRCG_KEY_SPM ##[1:4] nvm_cmd_ok);
    c_sp_pair: cover property (apb_wr && idx == `CRCG_IDX_SPL ##[2:6] apb_wr && idx == `CRCG_IDX_SPH);

endmodule // crcg_top

// file: tb/crcg_cpu_model.sv
// Purpose: cpu execution side that retires instructions and raises guard events
// Assumes: one bench process calls these tasks at a time
// Notes:   every output changes by non-blocking assignment right after a rising edge
`timescale 1ns/100ps
module crcg_cpu_model (
    input  wire logic ref_clk,
    output logic      instr_done,
    output logic      io_data_wr,
    output logic      nvm_access,
    output logic      sleep_exec,
    output logic      prot_io_wr,
    output logic      nvm_cmd_wr,
    output logic      irq_req
);
    logic [4:0] ev;

    // event codes: 0 io or data write, 1 nvm access, 2 sleep, 3 protected write, 4 nvm command
    assign {nvm_cmd_wr, prot_io_wr, sleep_exec, nvm_access, io_data_wr} = ev;

    // idle at time zero so the guard sees no stray close event
    initial
    begin
        ev         = 5'h00;
        instr_done = 1'b0;
        irq_req    = 1'b0;
    end

    // one event held for one cycle, then every event line is cleared again
    task automatic pulse(input int k);
        @(posedge ref_clk);
        ev <= 5'h01 << k;
        @(posedge ref_clk);
        ev <= 5'h00;
    endtask

    // n back-to-back retirements; instr_done is held high for n cycles
    task automatic retire(input int n);
        @(posedge ref_clk);
        instr_done <= 1'b1;
        repeat (n) @(posedge ref_clk);
        instr_done <= 1'b0;
    endtask

    // request is a level, held as set until the next call changes it, never cleared on service
    task automatic set_irq(input int v);
        @(posedge ref_clk);
        irq_req <= v[0];
    endtask
endmodule // crcg_cpu_model

// file: tb/crcg_top_bench.sv
// Purpose: self-checking bench for register file, pointer pairs, temp byte and config guard
// Assumes: apb answers one cycle after setup; register ports answer on the next edge
// Notes:   expectations come from the integer model here, never from design outputs
`timescale 1ns/100ps
`include "crcg_params.svh"
module crcg_top_bench;
    import crcg_pkg::*;
    logic           ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]     paddr, rd_a_data, rd_b_data;
    logic [31:0]    pwdata, prdata;
    logic [4:0]     rd_a_addr, rd_b_addr, wr_addr;
    logic [15:0]    rd_w_data, wr_data, ptr_addr, code_ptr;
    logic           wr_en, wr_wide, ptr_go, prot_io_ok, nvm_cmd_ok, irq_hold, irq_take;
    logic [1:0]     ptr_sel;
    logic [5:0]     ptr_disp;
    crcg_ptr_mode_e ptr_mode;
    logic           instr_done, io_data_wr, nvm_access, sleep_exec, prot_io_wr, nvm_cmd_wr, irq_req;
    int             n_errors, tests_run, seed, sp_m, tmp_m, status_flags_m, mode_m, left_m;
    int             rf_m [32];
    logic [7:0]     keys [3] = '{`CRCG_KEY_IO, `CRCG_KEY_SPM, 8'h55};

    crcg_top i_crcg_top (.ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .rd_a_addr, .rd_b_addr, .rd_a_data, .rd_b_data, .rd_w_data, .wr_en, .wr_wide, .wr_addr,
        .wr_data, .ptr_go, .ptr_sel, .ptr_mode, .ptr_disp, .ptr_addr, .code_ptr, .instr_done, .io_data_wr,
        .nvm_access, .sleep_exec, .prot_io_wr, .nvm_cmd_wr, .prot_io_ok, .nvm_cmd_ok, .irq_req, .irq_hold,
        .irq_take);
    crcg_cpu_model i_crcg_cpu_model (.ref_clk, .instr_done, .io_data_wr, .nvm_access, .sleep_exec,
        .prot_io_wr, .nvm_cmd_wr, .irq_req);

    // 20 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // model state after any reset
    task automatic model_reset();
        foreach (rf_m[i]) rf_m[i] = 0;
        sp_m   = `CRCG_SP_RST;
        tmp_m  = 0;
        status_flags_m = 0;
        mode_m = 0;
    endtask

    // one apb transfer, held until pready is sampled high; upper write bits are junk on purpose
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        logic [31:0] junk;
        junk = $random(seed);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {junk[31:8], wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // register access with the model updated in step; guard mode 1 io, 2 self-program
    task automatic reg_op(input bit wr, input logic [5:0] idx, input int d);
        logic [31:0] rd;
        logic        err;
        int          exp;
        bit          ok;
        d = d & 32'h0000_00FF;
        ok = idx inside {`CRCG_IDX_GUARD, `CRCG_IDX_SPL, `CRCG_IDX_SPH, `CRCG_IDX_STATUS_FLAGS, `CRCG_IDX_TEMP};
        case (idx)
            `CRCG_IDX_GUARD: exp = mode_m;
            `CRCG_IDX_SPL: exp = sp_m & 255;
            `CRCG_IDX_SPH, `CRCG_IDX_TEMP: exp = tmp_m;
            `CRCG_IDX_STATUS_FLAGS: exp = status_flags_m;
            default: exp = 0;
        endcase
        if (!wr && idx == `CRCG_IDX_SPL)
            tmp_m = sp_m >> 8;
        // any write but a key closes the io window, mapped or not
        if (wr && mode_m == 1 && idx != `CRCG_IDX_GUARD)
            mode_m = 0;
        if (wr && ok)
        begin
            case (idx)
                `CRCG_IDX_GUARD: mode_m = (d == `CRCG_KEY_IO) ? 1 : (d == `CRCG_KEY_SPM) ? 2 : 0;
                `CRCG_IDX_SPL, `CRCG_IDX_TEMP: tmp_m = d;
                `CRCG_IDX_SPH: sp_m = d * 256 + tmp_m;
                default: status_flags_m = d;
            endcase
        end
        apb(wr, idx, d[7:0], rd, err);
        check(err, !ok);
        if (!wr)
            check(rd, exp);
    endtask

    task automatic rf_write(input int a, input int d, input bit w);
        @(posedge ref_clk);
        wr_en   <= 1'b1;
        wr_wide <= w;
        wr_addr <= a[4:0];
        wr_data <= d[15:0];
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        rf_m[w ? (a & 30) : a] = d & 255;
        if (w)
            rf_m[a | 1] = (d >> 8) & 255;
    endtask

    // two byte reads and the paired 16-bit read in one cycle
    task automatic rf_read(input int a, input int b);
        @(posedge ref_clk);
        rd_a_addr <= a[4:0];
        rd_b_addr <= b[4:0];
        @(posedge ref_clk);
        #1;
        check(rd_a_data, rf_m[a]);
        check(rd_b_data, rf_m[b]);
        check(rd_w_data, rf_m[a | 1] * 256 + rf_m[a & 30]);
    endtask

    // pointer step; selector 3 falls onto the third pair as 2 does
    task automatic ptr_op(input int s, input int m, input int disp);
        int lo;
        int p;
        lo = `CRCG_PTR_X + 2 * (s > 2 ? 2 : s);
        p = rf_m[lo + 1] * 256 + rf_m[lo];
        disp = disp & 63;
        @(posedge ref_clk);
        ptr_go   <= 1'b1;
        ptr_sel  <= s[1:0];
        ptr_mode <= crcg_ptr_mode_e'(m);
        ptr_disp <= disp[5:0];
        @(posedge ref_clk);
        ptr_go   <= 1'b0;
        #1;
        check(ptr_addr, ((m == 0) ? p + disp : (m == 1) ? p : p - 1) & 16'hFFFF);
        p = ((m == 1) ? p + 1 : (m == 2) ? p - 1 : p) & 16'hFFFF;
        rf_m[lo] = p & 255;
        rf_m[lo + 1] = p >> 8;
        rf_read(lo, lo + 1);
        check(code_ptr, rf_m[31] * 256 + rf_m[30]);
    endtask

    task automatic guard_chk();
        @(posedge ref_clk);
        #1;
        check(irq_hold, mode_m != 0);
        check(irq_take, irq_req && mode_m == 0);
        reg_op(0, `CRCG_IDX_GUARD, 0);
    endtask

    task automatic event_chk(input int k);
        i_crcg_cpu_model.pulse(k);
        #1;
        check(prot_io_ok, k == 3 && mode_m == 1);
        check(nvm_cmd_ok, k == 4 && mode_m == 2);
        if ((mode_m == 1 && k < 3) || k == 1 || k == 2)
            mode_m = 0;
    endtask

    //////////////////////////////////////////////////////////////////////////////////////////
    // watchdog well beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("ERROR at %0t: run did not finish", $time);
        give_verdict();
    end

    initial
    begin
        {n_errors, tests_run, seed} = {32'h0, 32'h0, 32'h3A};
        {rst_n, psel, penable, pwrite, wr_en, wr_wide, ptr_go} = 7'h00;
        {paddr, pwdata, rd_a_addr, rd_b_addr, wr_addr, wr_data, ptr_sel, ptr_disp} = '0;
        ptr_mode = CRCG_DISP;
        model_reset();
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        // reset values, unmapped places, then the stack pointer low byte first
        foreach (keys[i]) reg_op(0, i == 0 ? `CRCG_IDX_GUARD : `CRCG_IDX_SPL + i - 1, 0);
        reg_op(0, `CRCG_IDX_STATUS_FLAGS, 0);
        reg_op(1, 6'h01, 'hA5);
        reg_op(0, 6'h3F, 0);
        repeat (4)
        begin
            reg_op(1, `CRCG_IDX_SPL, $random(seed));
            reg_op(0, `CRCG_IDX_TEMP, 0);
            reg_op(1, `CRCG_IDX_SPH, $random(seed));
            reg_op(0, `CRCG_IDX_SPL, 0);
            reg_op(0, `CRCG_IDX_SPH, 0);
            reg_op(1, `CRCG_IDX_TEMP, $random(seed));
            reg_op(0, `CRCG_IDX_TEMP, 0);
            reg_op(1, `CRCG_IDX_STATUS_FLAGS, $random(seed));
            reg_op(0, `CRCG_IDX_STATUS_FLAGS, 0);
        end
        // all working registers, then pointers with the first pair at all ones so steps wrap
        for (int i = 0; i < 32; i++) rf_write(i, $random(seed), 0);
        for (int i = 0; i < 32; i++) rf_read(i, 31 - i);
        rf_write(`CRCG_PTR_X, 16'hFFFF, 1);
        for (int s = 0; s < 4; s++)
            for (int m = 0; m < 3; m++) ptr_op(s, m, $random(seed));
        // every key against the io write, nvm access and sleep close events and the four-instruction boundary
        for (int g = 0; g < 3; g++)
            for (int k = 0; k < 5; k++)
            begin
                i_crcg_cpu_model.set_irq($random(seed));
                reg_op(1, `CRCG_IDX_GUARD, keys[g]);
                left_m = 4;
                guard_chk();
                event_chk(3);
                event_chk(4);
                if (k < 3)
                    event_chk(k);
                else
                    i_crcg_cpu_model.retire(k);
                left_m -= (k < 3) ? 0 : k;
                mode_m = (left_m <= 0) ? 0 : mode_m;
                event_chk(3);
                event_chk(4);
                guard_chk();
            end
        // four retirements right behind the key edge: the window ends on the fourth
        fork
            reg_op(1, `CRCG_IDX_GUARD, `CRCG_KEY_IO);
            begin
                repeat (2) @(posedge ref_clk);
                i_crcg_cpu_model.retire(4);
            end
        join
        mode_m = 0;
        guard_chk();
        // reset in the middle of an open window
        reg_op(1, `CRCG_IDX_GUARD, `CRCG_KEY_IO);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        model_reset();
        guard_chk();
        rf_read(`CRCG_PTR_Z, 0);
        give_verdict();
    end
endmodule // crcg_top_bench
